// ===== ccibc_map.svh
// What this block does
// - Pass-through bit forwards every I2C transaction
// - SDA input hold is field times 50 ns
// - Glitch filter width is depth times 10 ns
// - Forward sequence error sets read-only flag
// - Clear bit clears the sequence error flag
// - SDA output delay 350 ns plus 50 ns steps
// - Write-disable rejects remote writes to registers
// - Write-disable leaves remote slave access alone
// - Watchdog expires 50 us fast, 1 s slow
// - Quiet low SDA at expiry: nine SCL pulses
// - Pin-config bit picks pin or register self-test
// - Register enable bit starts and stops self-test
`ifndef CCIBC_MAP_SVH
`define CCIBC_MAP_SVH
`define CCIBC_OFF_CTL1        8'h21
`define CCIBC_OFF_CTL2        8'h22
`define CCIBC_OFF_SCRATCH     8'h23
`define CCIBC_OFF_SELFTEST    8'h24
`define CCIBC_RST_CTL1        8'h00
`define CCIBC_RST_CTL2        8'h00
`define CCIBC_RST_SCRATCH     8'h00
`define CCIBC_RST_SELFTEST    8'h08
`define CCIBC_BIT_PASS        7
`define CCIBC_HOLD_HI         6
`define CCIBC_HOLD_LO         4
`define CCIBC_FLT_HI          3
`define CCIBC_FLT_LO          0
`define CCIBC_BIT_SEQERR      7
`define CCIBC_BIT_SEQCLR      6
`define CCIBC_ODLY_HI         4
`define CCIBC_ODLY_LO         3
`define CCIBC_BIT_LWD         2
`define CCIBC_BIT_WDFAST      1
`define CCIBC_BIT_WDDIS       0
`define CCIBC_BIT_STPIN       3
`define CCIBC_STCLK_HI        2
`define CCIBC_STCLK_LO        1
`define CCIBC_BIT_STEN        0
`define CCIBC_CLK_NS          50
`define CCIBC_HOLD_STEP_NS    50
`define CCIBC_FLT_STEP_NS     10
`define CCIBC_ODLY_BASE_NS    350
`define CCIBC_ODLY_STEP_NS    50
`define CCIBC_WD_FAST_NS      50000
`define CCIBC_WD_SLOW_S       1
`define CCIBC_REC_HALF_NS     5000
`define CCIBC_REC_PULSES      9
`define CCIBC_WD_FAST_CYC     (`CCIBC_WD_FAST_NS / `CCIBC_CLK_NS)
`define CCIBC_WD_SLOW_CYC     (`CCIBC_WD_SLOW_S * 1000000000 / `CCIBC_CLK_NS)
`define CCIBC_REC_HALF_CYC    (`CCIBC_REC_HALF_NS / `CCIBC_CLK_NS)
`define CCIBC_ODLY_BASE_CYC   (`CCIBC_ODLY_BASE_NS / `CCIBC_CLK_NS)
`define CCIBC_ODLY_STEP_CYC   (`CCIBC_ODLY_STEP_NS / `CCIBC_CLK_NS)
`define CCIBC_HOLD_STEP_CYC   (`CCIBC_HOLD_STEP_NS / `CCIBC_CLK_NS)
`endif

// ===== ccibc_pkg.sv
package ccibc_pkg;
   typedef enum logic [1:0] {
      CCIBC_WD_IDLE = 2'b00,
      CCIBC_WD_LOW  = 2'b01,
      CCIBC_WD_HIGH = 2'b10
   } ccibc_wd_state_t;
endpackage

// ===== ccibc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccibc_map.svh"
module ccibc_top
   import ccibc_pkg::*;
#(
   parameter int WD_SLOW_CYC = `CCIBC_WD_SLOW_CYC
) (
   input  wire logic       CLOCK_I,
   input  wire logic       RESET_I,
   input  wire logic       LINK_CLK_I,
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   input  wire logic       REG_WR_I,
   input  wire logic       REG_REMOTE_I,
   output logic      [7:0] REG_RDATA_O,
   input  wire logic       LINK_SEQ_ERR_I,
   output logic            LINK_PASS_O,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SCL_O,
   output logic            SCL_OE_O,
   output logic            SDA_O,
   output logic            SDA_OE_O,
   input  wire logic       CH_SCL_I,
   input  wire logic       CH_SDA_I,
   output logic            FWD_SCL_O,
   output logic            FWD_SDA_O,
   output logic            FWD_EN_O,
   output logic            BUS_FREE_O,
   input  wire logic       SELFTEST_PIN_I,
   output logic            SELFTEST_ON_O,
   output logic      [1:0] SELFTEST_CLK_O
);
   localparam int WDW = 25;
   localparam int ODN = 12;

   logic [7:0] ctl1_r;
   logic [7:0] ctl2_r;
   logic [7:0] scratch_r;
   logic [7:0] stc_r;
   logic       seq_err_r;
   logic       wr_ok;

   // Register writes; remote writes are dropped under write-disable
   assign wr_ok = REG_WR_I & ~(REG_REMOTE_I & ctl2_r[`CCIBC_BIT_LWD]);

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         ctl1_r    <= `CCIBC_RST_CTL1;
         ctl2_r    <= `CCIBC_RST_CTL2;
         scratch_r <= `CCIBC_RST_SCRATCH;
         stc_r     <= `CCIBC_RST_SELFTEST;
      end else if (wr_ok) begin
         if (REG_ADDR_I == `CCIBC_OFF_CTL1) begin
            ctl1_r <= REG_WDATA_I;
         end else if (REG_ADDR_I == `CCIBC_OFF_CTL2) begin
            // Error flag bit and reserved bit are not writable
            ctl2_r <= REG_WDATA_I & 8'h5f;
         end else if (REG_ADDR_I == `CCIBC_OFF_SCRATCH) begin
            scratch_r <= REG_WDATA_I;
         end else if (REG_ADDR_I == `CCIBC_OFF_SELFTEST) begin
            stc_r <= REG_WDATA_I & 8'h0f;
         end
      end
   end

   // Read data, registered; unmapped offsets read zero
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_ADDR_I == `CCIBC_OFF_CTL1) begin
         REG_RDATA_O <= ctl1_r;
      end else if (REG_ADDR_I == `CCIBC_OFF_CTL2) begin
         REG_RDATA_O <= {seq_err_r, ctl2_r[6:0]};
      end else if (REG_ADDR_I == `CCIBC_OFF_SCRATCH) begin
         REG_RDATA_O <= scratch_r;
      end else if (REG_ADDR_I == `CCIBC_OFF_SELFTEST) begin
         REG_RDATA_O <= stc_r;
      end else begin
         REG_RDATA_O <= 8'h00;
      end
   end

   // Link domain: error pulses become a toggle, pass bit is synced in
   logic seq_tgl_r;
   logic pass_s1_r;
   logic pass_s2_r;
   always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         seq_tgl_r <= 1'b0;
      end else if (LINK_SEQ_ERR_I) begin
         seq_tgl_r <= ~seq_tgl_r;
      end
   end
   always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         pass_s1_r   <= 1'b0;
         pass_s2_r   <= 1'b0;
         LINK_PASS_O <= 1'b0;
      end else begin
         pass_s1_r   <= ctl1_r[`CCIBC_BIT_PASS];
         pass_s2_r   <= pass_s1_r;
         LINK_PASS_O <= pass_s2_r;
      end
   end

   // Toggle crossing into the register domain
   logic [2:0] seq_sync_r;
   logic       seq_evt;
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         seq_sync_r <= 3'b000;
      end else begin
         seq_sync_r <= {seq_sync_r[1:0], seq_tgl_r};
      end
   end
   assign seq_evt = seq_sync_r[2] ^ seq_sync_r[1];

   // Clear bit holds the flag clear for as long as it is set
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         seq_err_r <= 1'b0;
      end else if (ctl2_r[`CCIBC_BIT_SEQCLR]) begin
         seq_err_r <= 1'b0;
      end else if (seq_evt) begin
         seq_err_r <= 1'b1;
      end
   end

   // Pin synchronisers
   logic [1:0] scl_s_r;
   logic [1:0] sda_s_r;
   logic [1:0] stp_s_r;
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         scl_s_r <= 2'b11;
         sda_s_r <= 2'b11;
         stp_s_r <= 2'b00;
      end else begin
         scl_s_r <= {scl_s_r[0], SCL_I};
         sda_s_r <= {sda_s_r[0], SDA_I};
         stp_s_r <= {stp_s_r[0], SELFTEST_PIN_I};
      end
   end

   // Glitch filter: a new level must stand longer than the depth
   logic [4:0] flt_cyc;
   logic       scl_f_r;
   logic       sda_f_r;
   logic [4:0] scl_cnt_r;
   logic [4:0] sda_cnt_r;
   assign flt_cyc = 5'((ctl1_r[`CCIBC_FLT_HI:`CCIBC_FLT_LO]
                    * `CCIBC_FLT_STEP_NS + `CCIBC_CLK_NS - 1)
                    / `CCIBC_CLK_NS);

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         scl_f_r   <= 1'b1;
         scl_cnt_r <= 5'h00;
      end else if (scl_s_r[1] == scl_f_r) begin
         scl_cnt_r <= 5'h00;
      end else if (scl_cnt_r >= flt_cyc) begin
         scl_f_r   <= scl_s_r[1];
         scl_cnt_r <= 5'h00;
      end else begin
         scl_cnt_r <= scl_cnt_r + 5'h01;
      end
   end
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sda_f_r   <= 1'b1;
         sda_cnt_r <= 5'h00;
      end else if (sda_s_r[1] == sda_f_r) begin
         sda_cnt_r <= 5'h00;
      end else if (sda_cnt_r >= flt_cyc) begin
         sda_f_r   <= sda_s_r[1];
         sda_cnt_r <= 5'h00;
      end else begin
         sda_cnt_r <= sda_cnt_r + 5'h01;
      end
   end

   // SDA input hold: SDA seen late against SCL by whole clock steps
   logic [7:0] sda_hold_r;
   logic [2:0] hold_tap;
   logic       sda_held;
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sda_hold_r <= 8'hff;
      end else begin
         sda_hold_r <= {sda_hold_r[6:0], sda_f_r};
      end
   end
   assign hold_tap = 3'(ctl1_r[`CCIBC_HOLD_HI:`CCIBC_HOLD_LO]
                     * `CCIBC_HOLD_STEP_CYC);
   assign sda_held = (hold_tap == 3'h0) ? sda_f_r
                                        : sda_hold_r[hold_tap - 3'h1];

   // Forwarding toward the channel; write-disable does not gate it
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         FWD_EN_O  <= 1'b0;
         FWD_SCL_O <= 1'b1;
         FWD_SDA_O <= 1'b1;
      end else begin
         FWD_EN_O  <= ctl1_r[`CCIBC_BIT_PASS];
         FWD_SCL_O <= scl_f_r;
         FWD_SDA_O <= sda_held;
      end
   end

   // SDA output delay line, 350 ns at code 00
   logic [ODN-1:0] sda_od_r;
   logic [3:0]     od_tap;
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sda_od_r <= '1;
      end else begin
         sda_od_r <= {sda_od_r[ODN-2:0], CH_SDA_I};
      end
   end
   assign od_tap = 4'(`CCIBC_ODLY_BASE_CYC - 1 + `CCIBC_ODLY_STEP_CYC
                   * ctl2_r[`CCIBC_ODLY_HI:`CCIBC_ODLY_LO]);
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         SDA_O    <= 1'b0;
         SDA_OE_O <= 1'b0;
      end else begin
         SDA_O    <= 1'b0;
         SDA_OE_O <= ~sda_od_r[od_tap];
      end
   end

   // Bus watchdog
   ccibc_wd_state_t wd_st_r;
   logic [WDW-1:0]  wd_cnt_r;
   logic [WDW-1:0]  wd_lim;
   logic [7:0]      rec_cnt_r;
   logic [3:0]      rec_pls_r;
   logic            scl_d_r;
   logic            sda_d_r;
   logic            act;
   logic            wd_en;
   logic            rec_scl_low;
   assign wd_en  = ~ctl2_r[`CCIBC_BIT_WDDIS];
   assign wd_lim = ctl2_r[`CCIBC_BIT_WDFAST]
                   ? WDW'(`CCIBC_WD_FAST_CYC) : WDW'(WD_SLOW_CYC);
   assign act    = (scl_d_r != scl_f_r) | (sda_d_r != sda_f_r);
   assign rec_scl_low = (wd_st_r == CCIBC_WD_LOW);

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_f_r;
         sda_d_r <= sda_f_r;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         wd_st_r    <= CCIBC_WD_IDLE;
         wd_cnt_r   <= '0;
         rec_cnt_r  <= 8'h00;
         rec_pls_r  <= 4'h0;
         BUS_FREE_O <= 1'b0;
      end else begin
         case (wd_st_r)
            CCIBC_WD_IDLE: begin
               if (!wd_en || act) begin
                  wd_cnt_r   <= '0;
                  BUS_FREE_O <= 1'b0;
               end else if (wd_cnt_r >= wd_lim - WDW'(1)) begin
                  wd_cnt_r <= '0;
                  if (sda_f_r) begin
                     BUS_FREE_O <= 1'b1;
                  end else begin
                     wd_st_r   <= CCIBC_WD_LOW;
                     rec_cnt_r <= 8'h00;
                     rec_pls_r <= 4'h0;
                  end
               end else begin
                  wd_cnt_r <= wd_cnt_r + WDW'(1);
               end
            end
            CCIBC_WD_LOW: begin
               if (rec_cnt_r == 8'(`CCIBC_REC_HALF_CYC - 1)) begin
                  rec_cnt_r <= 8'h00;
                  wd_st_r   <= CCIBC_WD_HIGH;
               end else begin
                  rec_cnt_r <= rec_cnt_r + 8'h01;
               end
            end
            CCIBC_WD_HIGH: begin
               if (rec_cnt_r == 8'(`CCIBC_REC_HALF_CYC - 1)) begin
                  rec_cnt_r <= 8'h00;
                  if (rec_pls_r == 4'(`CCIBC_REC_PULSES - 1)) begin
                     wd_st_r <= CCIBC_WD_IDLE;
                  end else begin
                     rec_pls_r <= rec_pls_r + 4'h1;
                     wd_st_r   <= CCIBC_WD_LOW;
                  end
               end else begin
                  rec_cnt_r <= rec_cnt_r + 8'h01;
               end
            end
            default: begin
               wd_st_r <= CCIBC_WD_IDLE;
            end
         endcase
      end
   end

   // SCL driven low by recovery pulses or by the channel side
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         SCL_O    <= 1'b0;
         SCL_OE_O <= 1'b0;
      end else begin
         SCL_O    <= 1'b0;
         SCL_OE_O <= rec_scl_low | ~CH_SCL_I;
      end
   end

   // Self-test control: pin or register bit selects the source
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         SELFTEST_ON_O  <= 1'b0;
         SELFTEST_CLK_O <= 2'b00;
      end else begin
         SELFTEST_ON_O  <= stc_r[`CCIBC_BIT_STPIN] ? stp_s_r[1]
                           : stc_r[`CCIBC_BIT_STEN];
         SELFTEST_CLK_O <= stc_r[`CCIBC_STCLK_HI:`CCIBC_STCLK_LO];
      end
   end
endmodule
`default_nettype wire

// ===== ccibc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccibc_properties (
   input wire logic       CLOCK_I,
   input wire logic       RESET_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic       REG_WR_I,
   input wire logic       REG_REMOTE_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic       SCL_O,
   input wire logic       SDA_O,
   input wire logic       SCL_OE_O,
   input wire logic       SDA_OE_O,
   input wire logic       CH_SCL_I,
   input wire logic       CH_SDA_I,
   input wire logic       FWD_EN_O,
   input wire logic       BUS_FREE_O,
   input wire logic       SELFTEST_ON_O,
   input wire logic [1:0] SELFTEST_CLK_O
);
   logic [7:0] scr_r;
   logic [7:0] ctl2_r;
   logic [7:0] st_r;
   logic       pass_r;
   logic       acc;
   // Shadow copies let reads be judged without peeking inside
   assign acc = REG_WR_I && !(REG_REMOTE_I && ctl2_r[2]);
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         scr_r <= 8'h00;
         ctl2_r <= 8'h00;
         st_r <= 8'h08;
         pass_r <= 1'b0;
      end else if (acc) begin
         if (REG_ADDR_I == 8'h21) pass_r <= REG_WDATA_I[7];
         if (REG_ADDR_I == 8'h22) ctl2_r <= REG_WDATA_I & 8'h5f;
         if (REG_ADDR_I == 8'h23) scr_r <= REG_WDATA_I;
         if (REG_ADDR_I == 8'h24) st_r <= REG_WDATA_I & 8'h0f;
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   chk_pins_low: assert property (!SCL_O && !SDA_O)
      else $error("Open-drain data not low");
   chk_scratch_read: assert property
      ($past(REG_ADDR_I) == 8'h23 |-> REG_RDATA_O == $past(scr_r))
      else $error("Scratch readback wrong");
   chk_ctl2_read: assert property
      ($past(REG_ADDR_I) == 8'h22 |-> REG_RDATA_O[6:0] == $past(ctl2_r[6:0]))
      else $error("Control two readback wrong");
   chk_flag_held: assert property
      ($past(REG_ADDR_I) == 8'h22 && $past(ctl2_r[6]) && $past(ctl2_r[6], 2)
       |-> !REG_RDATA_O[7]) else $error("Error flag not held clear");
   chk_test_read: assert property
      ($past(REG_ADDR_I) == 8'h24 |-> REG_RDATA_O == $past(st_r))
      else $error("Self-test readback wrong");
   chk_unmapped_zero: assert property
      ($past(REG_ADDR_I) < 8'h21 || $past(REG_ADDR_I) > 8'h24
       |-> REG_RDATA_O == 8'h00) else $error("Unmapped read not zero");
   chk_pass_follow: assert property
      (acc && REG_ADDR_I == 8'h21 |-> ##2 FWD_EN_O == pass_r)
      else $error("Forward enable wrong");
   chk_test_on: assert property
      ((!st_r[3] && $stable(st_r[0]))[*3] |-> SELFTEST_ON_O == st_r[0])
      else $error("Self-test state wrong");
   chk_clk_source: assert property
      ($stable(st_r)[*3] |-> SELFTEST_CLK_O == st_r[2:1])
      else $error("Self-test clock source wrong");
   chk_recover_low: assert property
      ($rose(SCL_OE_O) && CH_SCL_I && $past(CH_SCL_I) |-> SCL_OE_O[*8])
      else $error("Recovery low phase too short");
   chk_sda_delay: assert property
      ($fell(CH_SDA_I) |-> !SDA_OE_O[*6] ##[1:7] SDA_OE_O)
      else $error("SDA output delay out of range");
   cover property (acc && REG_REMOTE_I);
   cover property ($rose(BUS_FREE_O));
   cover property ($rose(SCL_OE_O));
endmodule
bind ccibc_top ccibc_properties u_chk (.CLOCK_I, .RESET_I, .REG_ADDR_I,
   .REG_WDATA_I, .REG_WR_I, .REG_REMOTE_I, .REG_RDATA_O, .SCL_O, .SDA_O,
   .SCL_OE_O, .SDA_OE_O, .CH_SCL_I, .CH_SDA_I, .FWD_EN_O, .BUS_FREE_O,
   .SELFTEST_ON_O, .SELFTEST_CLK_O);
`default_nettype wire

// ===== ccibc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccibc_bus_model (
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   input  wire logic hold_scl_low_i,
   input  wire logic hold_sda_low_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Pull-ups: a released line reads high, any party wins low
   assign scl_o = !(scl_oe_i || hold_scl_low_i);
   assign sda_o = !(sda_oe_i || hold_sda_low_i);
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk, lclk, rst, wr_s, rem, seq, ch_sda, ch_scl, pin;
   logic       scl_low, sda_low, scl_in, sda_in, scl_oe, sda_oe;
   logic       pass_l, fwd_scl, fwd_sda, fwd_en, bfree, st_on, prev;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] st_clk;
   int         n_fail, samples_checked;
   ccibc_top #(.WD_SLOW_CYC(200)) dut (.CLOCK_I(clk), .RESET_I(rst),
      .LINK_CLK_I(lclk), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr_s), .REG_REMOTE_I(rem), .REG_RDATA_O(rdata),
      .LINK_SEQ_ERR_I(seq), .LINK_PASS_O(pass_l), .SCL_I(scl_in),
      .SDA_I(sda_in), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_O(),
      .SDA_OE_O(sda_oe), .CH_SCL_I(ch_scl), .CH_SDA_I(ch_sda),
      .FWD_SCL_O(fwd_scl), .FWD_SDA_O(fwd_sda), .FWD_EN_O(fwd_en),
      .BUS_FREE_O(bfree), .SELFTEST_PIN_I(pin), .SELFTEST_ON_O(st_on),
      .SELFTEST_CLK_O(st_clk));
   ccibc_bus_model bus (.scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
      .hold_scl_low_i(scl_low), .hold_sda_low_i(sda_low),
      .scl_o(scl_in), .sda_o(sda_in));
   always #25 clk = ~clk;
   always #24 lclk = ~lclk;
   task final_report;
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cmpi(input string nm, input int e, input int g);
      samples_checked++;
      if (g != e) begin
         n_fail++;
         $display("Error %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d, input logic r);
      @(posedge clk) #2;
      {addr, wdata, wr_s, rem} = {a, d, 1'b1, r};
      @(posedge clk) #2;
      {wr_s, rem} = 2'b00;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk) #2;
      addr = a;
      @(posedge clk) #1;
      cmp("reg_read", e, rdata);
   endtask
   task err_pulse;
      @(posedge lclk) #2 seq = 1'b1;
      @(posedge lclk) #2 seq = 1'b0;
      cyc(12);
   endtask
   // Bounded wait; a hang shows up as the bound itself
   task lat(input int k, output int n);
      n = 0;
      while (n < 3000 && !((k == 0 && sda_oe === 1'b1) ||
             (k == 1 && fwd_sda === 1'b0) || (k == 2 && scl_oe === 1'b1))) begin
         @(posedge clk) #2;
         n++;
      end
   endtask
   initial begin
      #2_000_000;
      n_fail++;
      final_report();
   end
   initial begin
      int n, base, seen;
      {clk, lclk, wr_s, rem, seq, scl_low, sda_low, pin} = 8'h00;
      {addr, wdata, ch_sda, ch_scl, rst} = {16'h0000, 3'b111};
      cyc(20);
      rst = 1'b0;
      rchk(8'h22, 8'h00);
      rchk(8'h23, 8'h00);
      rchk(8'h24, 8'h08);
      rchk(8'h30, 8'h00);
      wr(8'h23, 8'ha5, 1'b0);
      rchk(8'h23, 8'ha5);
      wr(8'h21, 8'h80, 1'b0);
      cyc(6);
      cmp("pass", 8'h03, {6'h00, fwd_en, pass_l});
      wr(8'h24, 8'hf7, 1'b0);
      rchk(8'h24, 8'h07);
      cyc(4);
      cmp("selftest", 8'h07, {5'h00, st_on, st_clk});
      wr(8'h24, 8'h02, 1'b0);
      cyc(4);
      cmp("selftest", 8'h01, {5'h00, st_on, st_clk});
      wr(8'h24, 8'h08, 1'b0);
      pin = 1'b1;
      cyc(6);
      cmp("selftest", 8'h04, {5'h00, st_on, st_clk});
      wr(8'h22, 8'hff, 1'b0);
      rchk(8'h22, 8'h5f);
      err_pulse();
      rchk(8'h22, 8'h5f);
      wr(8'h22, 8'h04, 1'b0);
      rchk(8'h22, 8'h04);
      err_pulse();
      rchk(8'h22, 8'h84);
      wr(8'h23, 8'h3c, 1'b1);
      rchk(8'h23, 8'ha5);
      wr(8'h22, 8'h44, 1'b0);
      wr(8'h22, 8'h04, 1'b0);
      rchk(8'h22, 8'h04);
      for (int c = 0; c < 4; c++) begin
         wr(8'h22, {3'h0, 2'(c), 3'h4}, 1'b0);
         ch_sda = 1'b0;
         lat(0, n);
         if (c == 0) base = n;
         cmpi("sda_out_delay", base + c, n);
         ch_sda = 1'b1;
         cyc(30);
      end
      ch_scl = 1'b0;
      cyc(2);
      cmp("scl_out", 8'h01, {7'h00, scl_oe});
      ch_scl = 1'b1;
      cyc(2);
      cmp("scl_out", 8'h00, {7'h00, scl_oe});
      wr(8'h22, 8'h00, 1'b0);
      wr(8'h23, 8'h3c, 1'b1);
      rchk(8'h23, 8'h3c);
      for (int h = 0; h < 8; h += 7) begin
         wr(8'h21, {1'b0, 3'(h), 4'h0}, 1'b0);
         sda_low = 1'b1;
         lat(1, n);
         if (h == 0) base = n;
         cmpi("sda_hold", base + h, n);
         sda_low = 1'b0;
         cyc(30);
      end
      for (int d = 0; d < 16; d += 15) begin
         wr(8'h21, {4'h0, 4'(d)}, 1'b0);
         cyc(10);
         scl_low = 1'b1;
         cyc(3);
         scl_low = 1'b0;
         seen = 0;
         repeat (15) begin
            @(posedge clk) #1;
            if (fwd_scl === 1'b0) seen = 1;
         end
         cmpi("glitch", int'(d == 0), seen);
      end
      cyc(300);
      cmp("pass", 8'h00, {6'h00, fwd_en, pass_l});
      cmp("bus_free", 8'h01, {7'h00, bfree});
      sda_low = 1'b1;
      lat(2, n);
      cmpi("wd_slow", 1, int'(n > 190 && n < 230));
      {seen, prev} = {32'd1, 1'b1};
      repeat (1750) begin
         @(posedge clk) #1;
         if (scl_oe === 1'b1 && prev === 1'b0) seen++;
         prev = scl_oe;
      end
      cmpi("recovery_pulses", 9, seen);
      cyc(1);
      sda_low = 1'b0;
      cyc(100);
      cmp("bus_free", 8'h00, {7'h00, bfree});
      cyc(200);
      cmp("bus_free", 8'h01, {7'h00, bfree});
      wr(8'h22, 8'h01, 1'b0);
      sda_low = 1'b1;
      lat(2, n);
      cmpi("wd_off", 3000, n);
      wr(8'h22, 8'h02, 1'b0);
      lat(2, n);
      cmpi("wd_fast", 1, int'(n > 985 && n < 1030));
      final_report();
   end
endmodule
`default_nettype wire
